// File: supply_ctrl_pkg.sv
package supply_ctrl_pkg;

    // ========================================
    // register map, byte addresses
    localparam logic [3:0] ADDR_OUT_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DIAG_CTRL = 4'h4;
    localparam logic [3:0] ADDR_HW_CONFIG = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;

    // ========================================
    // field positions
    localparam int CFGREG_STATE_BIT = 3;
    localparam int CFGREG_LATCH_BIT = 2;
    localparam int CFGREG_CMD_BIT = 1;
    localparam int CFGREG_CTL_BIT = 0;
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_LIMP_BIT = 1;
    localparam int STAT_IDLE_BIT = 2;
    localparam int STAT_SUPPLY_BIT = 3;
    localparam int FIRST_ERR_BIT = 8;
    localparam int NUM_CH = 6;
    localparam int CRANK_CH = 5;

    localparam logic [2:0] MUX_STANDBY = 3'h7;

    typedef struct packed {
        logic [5:0] out_ctrl;
        logic [2:0] sense_mux_select;
        logic crank_latch_enable;
        logic ctl;
    } cfg_t;

    localparam cfg_t CFG_RST = '{
        out_ctrl: 6'h00,
        sense_mux_select: 3'h7,
        crank_latch_enable: 1'b1,
        ctl: 1'b0
    };

    // ========================================
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int POWERON_WAKEUP_NS = 100000;
    localparam int TRANSFER_DELAY_NS = 5000;
    localparam int WAKEUP_CYC =
        (POWERON_WAKEUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRANSFER_DELAY_CYC =
        (TRANSFER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;

endpackage

// File: sync2.sv
`timescale 1ns/1ps
module sync2
    import supply_ctrl_pkg::*;
#(
    parameter int W = 1
)(
    input wire logic clk_sys, // system clock
    input wire logic arst_n, // async reset
    input wire logic [W-1:0] d_async, // pin levels
    output logic [W-1:0] q_sync // synchronised levels
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    always_comb
    begin
        meta_nxt = d_async;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= '0;
            q_sync <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_sync <= q_nxt;
        end
    end
endmodule

// File: delay_timer.sv
`timescale 1ns/1ps
module delay_timer
    import supply_ctrl_pkg::*;
#(
    parameter int W = TIMER_W,
    parameter int LONG_CYC = WAKEUP_CYC,
    parameter int SHORT_CYC = TRANSFER_DELAY_CYC
)(
    input wire logic clk_sys, // system clock
    input wire logic arst_n, // async reset
    input wire logic load_long, // restart with wake-up time
    input wire logic load_short, // restart with transfer delay
    output logic busy // port not yet usable
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load_long)
            cnt_nxt = W'(LONG_CYC);
        else if (load_short)
            cnt_nxt = W'(SHORT_CYC);
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - W'(1);
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            cnt_r <= W'(LONG_CYC);
        else
            cnt_r <= cnt_nxt;
    end

    assign busy = (cnt_r != '0);
endmodule

// File: supply_mode_standby_reset_control.sv
// Summary of operation
// (RULE1) power-on reset restores every register default
// (RULE2) serial port works whenever logic supply good; here it is shut while the wake-up or transfer delay timer runs
// (RULE3) first frame returns output control, error set
// (RULE4) standby when mux at 111, ch5 off
// (RULE5) entering standby clears thermal latches
// (RULE6) standby flag set on standby entry
// (RULE7) host wakes device by non-default mux
// (RULE8) idle: channels off, mux non-default, supply
// (RULE9) limp home: outputs follow input pins only
// (RULE10) limp home disables the ch5 crank latch
// (RULE11) crank latch enable resets to one
// (RULE12) latched ch5 stays on until latch cleared
// (RULE13) host drops requests, then clears latch enable
// (RULE14) ch5 on/off state is readable
// (RULE15) no standby while ch5 is on
// (RULE16) resets restore registers, not power stages
// (RULE17) reset command acts like power-on reset
// (RULE18) limp home holds registers, ignores writes
// (RULE19) host waits wake-up time after power-on
// (RULE20) config reg: ch5 b3, latch b2, standby/reset b1
// (RULE21) reset command bit never reads back set; here bit 1 reads back the standby flag
`timescale 1ns/1ps
module supply_mode_standby_reset_control
    import supply_ctrl_pkg::*;
#(
    parameter int LONG_CYC = WAKEUP_CYC,
    parameter int SHORT_CYC = TRANSFER_DELAY_CYC
)(
    input wire logic clk_sys, // 20 MHz system clock
    input wire logic arst_n, // async reset, active low
    input wire logic [3:0] address, // avalon byte address
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic [31:0] writedata, // avalon write data
    output logic [31:0] readdata, // avalon read data
    output logic waitrequest, // avalon wait
    input wire logic logic_supply_ok, // logic supply in range pin
    input wire logic limp_home_input, // limp-home pin
    input wire logic [5:0] ch_input_pins, // input pins, bit 5 is ch5
    output logic [5:0] ch_on, // power stage enables
    output logic standby_flag, // device in stand-by
    output logic idle_mode, // idle mode active
    output logic thermal_latch_clear // clear pulse on standby entry
);
    // ========================================
    // pin synchronisers
    logic [7:0] pins_s;
    logic supply_s;
    logic limp_s;
    logic [5:0] in_s;

    sync2 #(.W(8)) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d_async({logic_supply_ok, limp_home_input, ch_input_pins}),
        .q_sync(pins_s)
    );

    assign supply_s = pins_s[7];
    assign limp_s = pins_s[6];
    assign in_s = pins_s[5:0];

    // ========================================
    // port availability timer
    logic soft_pend_r;
    logic busy;

    // holding the load while supply is out keeps the port shut
    delay_timer #(
        .W(TIMER_W),
        .LONG_CYC(LONG_CYC),
        .SHORT_CYC(SHORT_CYC)
    ) u_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load_long(!supply_s), // [RULE19] [RULE1]
        .load_short(soft_pend_r), // [RULE17]
        .busy(busy)
    );

    // ========================================
    // register bank and bus slave
    cfg_t cfg_r;
    cfg_t cfg_nxt;
    logic err_r;
    logic err_nxt;
    logic first_r;
    logic first_nxt;
    logic limp_d_r;
    logic soft_pend_nxt;
    logic wait_nxt;
    logic [31:0] rd_nxt;
    logic access;
    logic reset_event;

    assign access = (read || write) && waitrequest && !busy; // [RULE2]
    assign reset_event = !supply_s || soft_pend_r || (limp_s && !limp_d_r);

    always_comb
    begin
        cfg_nxt = cfg_r;
        err_nxt = err_r;
        first_nxt = first_r;
        soft_pend_nxt = 1'b0;
        wait_nxt = 1'b1;
        rd_nxt = readdata;
        if (access)
        begin
            wait_nxt = 1'b0;
            rd_nxt = 32'h0000_0000;
            if (first_r)
            begin
                // report is consumed by whatever access comes first
                rd_nxt[5:0] = cfg_r.out_ctrl; // [RULE3]
                rd_nxt[FIRST_ERR_BIT] = err_r; // [RULE3]
                first_nxt = 1'b0;
                err_nxt = 1'b0;
            end
            else
            begin
                unique case (address)
                    ADDR_OUT_CTRL: rd_nxt[5:0] = cfg_r.out_ctrl;
                    ADDR_DIAG_CTRL: rd_nxt[2:0] = cfg_r.sense_mux_select;
                    ADDR_HW_CONFIG:
                    begin
                        rd_nxt[CFGREG_STATE_BIT] = ch_on[CRANK_CH]; // [RULE14]
                        rd_nxt[CFGREG_LATCH_BIT] = cfg_r.crank_latch_enable;
                        rd_nxt[CFGREG_CMD_BIT] = standby_flag; // [RULE6]
                        rd_nxt[CFGREG_CTL_BIT] = cfg_r.ctl; // [RULE20]
                    end
                    ADDR_STATUS:
                    begin
                        rd_nxt[STAT_ERR_BIT] = err_r; // [RULE18]
                        rd_nxt[STAT_LIMP_BIT] = limp_s; // [RULE18]
                        rd_nxt[STAT_IDLE_BIT] = idle_mode;
                        rd_nxt[STAT_SUPPLY_BIT] = supply_s;
                    end
                    default: rd_nxt = 32'h0000_0000;
                endcase
            end
            if (write && !limp_s) // [RULE18]
            begin
                unique case (address)
                    ADDR_OUT_CTRL: cfg_nxt.out_ctrl = writedata[5:0];
                    ADDR_DIAG_CTRL:
                        cfg_nxt.sense_mux_select = writedata[2:0];
                    ADDR_HW_CONFIG:
                    begin
                        cfg_nxt.crank_latch_enable =
                            writedata[CFGREG_LATCH_BIT]; // [RULE20]
                        cfg_nxt.ctl = writedata[CFGREG_CTL_BIT];
                        // command bit is a trigger only, not stored
                        soft_pend_nxt = writedata[CFGREG_CMD_BIT]; // [RULE21]
                    end
                    default: ;
                endcase
            end
        end
        if (limp_s || !supply_s || soft_pend_r)
            cfg_nxt = CFG_RST; // [RULE1] [RULE11] [RULE17] [RULE18]
        if (reset_event)
        begin
            // set wins over the clear of a concurrent first access
            err_nxt = 1'b1; // [RULE3] [RULE16]
            first_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_r <= CFG_RST; // [RULE1]
            err_r <= 1'b1;
            first_r <= 1'b1;
            soft_pend_r <= 1'b0;
            limp_d_r <= 1'b0;
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            err_r <= err_nxt;
            first_r <= first_nxt;
            soft_pend_r <= soft_pend_nxt;
            limp_d_r <= limp_s;
            waitrequest <= wait_nxt;
            readdata <= rd_nxt;
        end
    end

    // ========================================
    // channels, crank latch and supply modes
    logic latch_r;
    logic latch_nxt;
    logic [5:0] ch_req;
    logic [5:0] ch_nxt;
    logic standby_nxt;
    logic idle_nxt;
    logic therm_nxt;

    // supply and command resets never touch latch_r, so a latched ch5 survives them; limp home clears it
    always_comb
    begin
        ch_req = limp_s ? in_s : (in_s | cfg_r.out_ctrl); // [RULE9]
        latch_nxt = latch_r;
        if (limp_s || !cfg_r.crank_latch_enable)
            latch_nxt = 1'b0; // [RULE10] [RULE13]
        else if (ch_req[CRANK_CH])
            latch_nxt = 1'b1; // [RULE12]
        ch_nxt = ch_req;
        ch_nxt[CRANK_CH] = ch_req[CRANK_CH] || latch_r; // [RULE12] [RULE16]
        standby_nxt = (cfg_r.sense_mux_select == MUX_STANDBY)
            && !ch_on[CRANK_CH] && !limp_s; // [RULE4] [RULE15]
        therm_nxt = standby_nxt && !standby_flag; // [RULE5]
        idle_nxt = (ch_nxt == 6'h00)
            && (cfg_r.sense_mux_select != MUX_STANDBY) && supply_s; // [RULE8]
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            latch_r <= 1'b0;
            ch_on <= 6'h00;
            standby_flag <= 1'b0;
            idle_mode <= 1'b0;
            thermal_latch_clear <= 1'b0;
        end
        else
        begin
            latch_r <= latch_nxt;
            ch_on <= ch_nxt;
            standby_flag <= standby_nxt; // [RULE6]
            idle_mode <= idle_nxt;
            thermal_latch_clear <= therm_nxt;
        end
    end

    // ========================================
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence seq_rst_cmd;
        access && write && !limp_s && (address == ADDR_HW_CONFIG)
            && writedata[CFGREG_CMD_BIT];
    endsequence

    sequence seq_rst_applied;
        soft_pend_r ##1 (cfg_r == CFG_RST && busy && first_r && err_r);
    endsequence

    a_rst_cmd_effect: assert property ( // [RULE17]
        seq_rst_cmd |=> seq_rst_applied)
        else $error("reset command did not restore defaults");

    a_rst_cmd_pulse: assert property ( // [RULE21]
        soft_pend_r |=> !soft_pend_r ##[1:3] !readdata[CFGREG_CMD_BIT]
            || standby_flag)
        else $error("reset command bit held");

    a_first_frame: assert property ( // [RULE3]
        first_r && access |=>
            readdata[5:0] == $past(cfg_r.out_ctrl)
            && readdata[FIRST_ERR_BIT] && !waitrequest && !first_r)
        else $error("first frame did not report control and error");

    a_port_answers: assert property ( // [RULE2]
        (read || write) && waitrequest && !busy
            |=> !waitrequest ##1 waitrequest)
        else $error("port did not answer in one cycle");

    a_standby_entry: assert property ( // [RULE4]
        cfg_r.sense_mux_select == MUX_STANDBY && !ch_on[CRANK_CH] && !limp_s
            |=> standby_flag)
        else $error("standby not entered");

    a_no_standby_ch5: assert property ( // [RULE15]
        ch_on[CRANK_CH] |=> !standby_flag)
        else $error("standby while ch5 on");

    a_thermal_clear: assert property ( // [RULE5]
        $rose(standby_flag) |-> thermal_latch_clear ##1 !thermal_latch_clear)
        else $error("thermal latches not cleared on standby");

    a_idle_mode: assert property ( // [RULE8]
        idle_mode |-> ch_on == 6'h00
            && $past(cfg_r.sense_mux_select) != MUX_STANDBY)
        else $error("idle flagged with channel on or default mux");

    a_limp_follow: assert property ( // [RULE9]
        limp_s && $past(limp_s) |=> ch_on == $past(in_s))
        else $error("limp outputs do not follow pins");

    a_limp_no_latch: assert property ( // [RULE10]
        limp_s |=> !latch_r)
        else $error("crank latch active in limp home");

    a_limp_hold: assert property ( // [RULE18]
        limp_s |=> cfg_r == CFG_RST)
        else $error("register written in limp home");

    a_latch_hold: assert property ( // [RULE12]
        latch_r && cfg_r.crank_latch_enable && !limp_s |=> ch_on[CRANK_CH])
        else $error("latched ch5 dropped");
endmodule

// File: host_bus.sv
`timescale 1ns/1ps
module host_bus (
    input wire logic clk_sys, // system clock
    input wire logic [31:0] readdata, // slave read data
    input wire logic waitrequest, // slave wait
    output logic [3:0] address, // byte address
    output logic read, // read strobe
    output logic write, // write strobe
    output logic [31:0] writedata // write data
);
    initial
    begin
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
    end

    // ========================================
    // one access, held until waitrequest is sampled low
    task automatic access(input logic wr, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q, output bit ok);
        ok = 1'b0;
        q = 32'h0;
        @(posedge clk_sys);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        for (int n = 0; n < 3000; n++)
        begin
            @(posedge clk_sys);
            if (waitrequest === 1'b0)
            begin
                q = readdata;
                ok = 1'b1;
                break;
            end
        end
        read <= 1'b0;
        write <= 1'b0;
        // released data no longer shows the last word
        writedata <= ~d;
    endtask
endmodule

// File: test_supply_mode_standby_reset_control.sv
`timescale 1ns/1ps
module test_supply_mode_standby_reset_control;
    import supply_ctrl_pkg::*;
    localparam int LC = 20;
    localparam int SC = 5;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic sup = 1'b1;
    logic limp = 1'b0;
    logic [5:0] pins = 6'h00;
    logic [3:0] address;
    logic read, write, waitrequest;
    logic [31:0] writedata, readdata, rd;
    logic [5:0] ch_on, out_m, exp_ch;
    logic standby_flag, idle_mode, thermal_latch_clear;
    logic [2:0] mux_m;
    logic latch_en_m, latch_m, exp_standby, ctl_m;
    logic [16:0] seed;
    bit ok;
    int errors = 0;
    int check_count = 0;
    int clr_cnt = 0;
    int c0;

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (thermal_latch_clear === 1'b1)
            clr_cnt++;

    supply_mode_standby_reset_control #(.LONG_CYC(LC), .SHORT_CYC(SC)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .logic_supply_ok(sup), .limp_home_input(limp),
        .ch_input_pins(pins), .ch_on(ch_on), .standby_flag(standby_flag),
        .idle_mode(idle_mode), .thermal_latch_clear(thermal_latch_clear)
    );
    host_bus bus (
        .clk_sys(clk_sys), .readdata(readdata), .waitrequest(waitrequest),
        .address(address), .read(read), .write(write),
        .writedata(writedata)
    );

    // ========================================
    // shared checking and bus tasks
    function automatic logic [16:0] nxt(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        bus.access(wr, a, d, rd, ok);
        if (!ok)
        begin
            errors++;
            report_and_stop();
        end
    endtask
    // two sync stages, channel and mode registers, then one to settle
    task automatic chk_out();
        repeat (5) @(posedge clk_sys);
        if (limp || !latch_en_m)
            latch_m = 1'b0;
        else if (pins[5] || out_m[5])
            latch_m = 1'b1;
        exp_ch = limp ? pins : (pins | out_m | {latch_m, 5'h00});
        exp_standby = mux_m == 3'h7 && !exp_ch[5] && !limp;
        chk("ch_on", ch_on, exp_ch);
        chk("standby", standby_flag, exp_standby);
        if (!limp)
            chk("idle", idle_mode, exp_ch == 0 && mux_m != 3'h7);
    endtask
    task automatic chk_hw();
        acc(1'b0, ADDR_HW_CONFIG, 32'h0);
        chk("config", rd, {exp_ch[5], latch_en_m, exp_standby,
            ctl_m});
    endtask

    // ========================================
    // main sequence
    initial
    begin
        seed = 17'h17c5d;
        out_m = 6'h00;
        mux_m = 3'h7;
        latch_en_m = 1'b1;
        latch_m = 1'b0;
        ctl_m = 1'b0;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (LC + 4) @(posedge clk_sys);
        acc(1'b0, ADDR_STATUS, 32'h0);
        chk("first", {rd[8], rd[5:0]}, 7'h40);
        acc(1'b0, ADDR_DIAG_CTRL, 32'h0);
        chk("mux", rd, 32'h7);
        chk_out();
        chk_hw();
        acc(1'b0, 4'h2, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("test reset done");
        c0 = clr_cnt;
        mux_m = 3'h3;
        acc(1'b1, ADDR_DIAG_CTRL, 32'h3);
        chk_out();
        chk("no clear", clr_cnt, c0);
        for (int i = 0; i < 8; i++)
        begin
            repeat (15) seed = nxt(seed);
            out_m = seed[5:0];
            mux_m = seed[8:6];
            acc(1'b1, ADDR_OUT_CTRL, {26'h0, out_m});
            acc(1'b1, ADDR_DIAG_CTRL, {29'h0, mux_m});
            pins <= seed[14:9];
            chk_out();
            chk_hw();
        end
        $display("test random done");
        out_m = 6'h20;
        acc(1'b1, ADDR_OUT_CTRL, 32'h20);
        pins <= 6'h00;
        chk_out();
        out_m = 6'h00;
        mux_m = 3'h7;
        acc(1'b1, ADDR_HW_CONFIG, 32'h6);
        acc(1'b0, ADDR_OUT_CTRL, 32'h0);
        chk("cmd first", {rd[8], rd[5:0]}, 7'h40);
        chk_out();
        chk_hw();
        c0 = clr_cnt;
        latch_en_m = 1'b0;
        ctl_m = 1'b1;
        acc(1'b1, ADDR_HW_CONFIG, 32'h1);
        chk_out();
        chk_hw();
        chk("clear pulse", clr_cnt, c0 + 1);
        $display("test latch done");
        out_m = 6'h0f;
        mux_m = 3'h3;
        acc(1'b1, ADDR_OUT_CTRL, 32'hf);
        acc(1'b1, ADDR_DIAG_CTRL, 32'h3);
        chk_out();
        limp <= 1'b1;
        pins <= 6'h21;
        out_m = 6'h00;
        mux_m = 3'h7;
        latch_en_m = 1'b1;
        ctl_m = 1'b0;
        chk_out();
        acc(1'b0, ADDR_STATUS, 32'h0);
        chk("limp first", rd[8], 1'b1);
        acc(1'b1, ADDR_OUT_CTRL, 32'h3f);
        acc(1'b0, ADDR_OUT_CTRL, 32'h0);
        chk("limp write", rd, 32'h0);
        acc(1'b0, ADDR_STATUS, 32'h0);
        chk("limp bit", rd[STAT_LIMP_BIT], 1'b1);
        limp <= 1'b0;
        pins <= 6'h00;
        chk_out();
        $display("test limp done");
        sup <= 1'b0;
        repeat (6) @(posedge clk_sys);
        sup <= 1'b1;
        acc(1'b0, ADDR_DIAG_CTRL, 32'h0);
        chk("supply first", rd[8], 1'b1);
        chk_out();
        chk_hw();
        $display("test supply done");
        report_and_stop();
    end
endmodule
